// >>> include/flash_ctrl_pkg.sv
// Constants and types shared by the flash write and erase controller.
// Assumes a 250 MHz APB clock and an array that ANDs programmed data.
package flash_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0c;
    localparam logic [7:0] OFS_TIMING = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Control register fields
    localparam int BIT_PAGE_ERASE = 0;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_CHIP_ERASE = 2;
    localparam int BIT_WORD_BUSY = 6;
    localparam int BIT_CTRL_BUSY = 7;
    // Status register field, write one to clear
    localparam int BIT_VIOLATION = 0;
    // Array organisation
    localparam int PAGE_BYTES = 2048;
    localparam int PAGE_COUNT = 64;
    localparam int WORD_ADDR_W = 15;
    localparam int PAGE_LSB = 1;
    localparam int PAGE_MSB = 6;
    // Reset values and the 16 MHz timing setting
    localparam logic [5:0] TIMING_RESET = 6'h2a;
    localparam logic [5:0] TIMING_16MHZ = 6'h15;
    localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
    localparam logic [6:0] ADDR_HIGH_RESET = 7'h00;
    // Timing figures and derived cycle counts
    localparam longint CLK_PERIOD_PS = 4000;
    localparam longint PROG_TIME_US = 20;
    localparam longint PAGE_ERASE_TIME_MS = 20;
    localparam longint CHIP_ERASE_TIME_MS = 200;
    localparam longint WORD_TIMEOUT_US = 40;
    localparam int PROG_CYCLES = int'((PROG_TIME_US * 1000000 +
        CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int PAGE_ERASE_CYCLES = int'((PAGE_ERASE_TIME_MS *
        1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int CHIP_ERASE_CYCLES = int'((CHIP_ERASE_TIME_MS *
        1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int TIMEOUT_CYCLES = int'((WORD_TIMEOUT_US * 1000000) /
        CLK_PERIOD_PS);

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_COLLECT = 4'b0100,
        ST_PROGRAM = 4'b1000
    } seq_state_e;

    // Command toward the flash array
    typedef struct packed {
        logic prog;
        logic page_erase;
        logic chip_erase;
        logic [5:0] page;
        logic [WORD_ADDR_W-1:0] addr;
        logic [31:0] data;
    } flash_cmd_s;
endpackage

// >>> hdl/embedded_flash_write_erase_ctrl.sv
// Flash write and page or chip erase sequencer with an APB register port.
// Assumes a DMA channel or the CPU feeds bytes and the array ANDs data.
//
// Contract
// [RULE1] Flash is pages of 2048 bytes; page erases, 32-bit word programs.
// [RULE2] Word address for writes is 15 bits, high register then low.
// [RULE3] Page erase selects page from high address bits 6 down to 1.
// [RULE4] Writing 1 to the write start bit begins writing at the address.
// [RULE5] Word write busy flag is high through each word programming.
// [RULE6] Stored bytes go to flash, first byte is least significant.
// [RULE7] Array is programmed only after four bytes are collected.
// [RULE8] Consecutive words may be programmed, address advancing each word.
// [RULE9] Programming only clears bits; at most two programs per erase.
// [RULE10] Erased bits read as one after page or chip erase.
// [RULE11] Programming one word takes about 20 us.
// [RULE12] Page erase takes about 20 ms.
// [RULE13] Chip erase takes about 200 ms.
// [RULE14] Processor flash accesses, fetches too, are blocked during a write.
// [RULE15] Code running a flash write must sit in RAM 0xE000 to 0xFEFF.
// [RULE16] Setting the write start bit does not stall the processor.
// [RULE17] Flash access while word busy raises an access violation.
// [RULE18] Write data comes from DMA or processor register accesses.
// [RULE19] Erase bit erases page; erase done before write, busy meanwhile.
// [RULE20] Four bytes within 40 us of busy falling, else write is dropped.
// [RULE21] A DMA request is raised whenever the port can take a new word.
// [RULE22] Program and erase timing follows a 6-bit setting, reset 0x2A.
// [RULE23] Byte position clears whenever a write is started or aborted.
`timescale 1ns/1ps
`default_nettype none
module embedded_flash_write_erase_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES,
    parameter int PAGE_ERASE_CNT = PAGE_ERASE_CYCLES,
    parameter int CHIP_ERASE_CNT = CHIP_ERASE_CYCLES,
    parameter int TIMEOUT_CNT = TIMEOUT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_flash_access,
    output logic cpu_flash_block,
    output logic dma_req,
    output flash_cmd_s flash_cmd
);
    // Durations in timing ticks, scaled so the reset setting gives the figure
    localparam int TICK_DIV = int'(TIMING_RESET);
    localparam int PROG_TICKS = (PROG_CNT + TICK_DIV - 1) / TICK_DIV;
    localparam int PAGE_TICKS = (PAGE_ERASE_CNT + TICK_DIV - 1) / TICK_DIV;
    localparam int CHIP_TICKS = (CHIP_ERASE_CNT + TICK_DIV - 1) / TICK_DIV;

    // Refuse counts too small for the counters to time
    if (PROG_CNT < 1 || PAGE_ERASE_CNT < 1 || CHIP_ERASE_CNT < 1 ||
        TIMEOUT_CNT < 2) begin : g_bad_param
        $error("flash sequencer: timing parameter too small");
    end

    seq_state_e state;
    seq_state_e next_state;
    logic [7:0] addr_low;
    logic [6:0] addr_high;
    logic [5:0] program_timing_setting;
    logic page_erase_bit;
    logic chip_erase_pend;
    logic write_start_bit;
    logic access_violation;
    logic [1:0] byte_idx;
    logic [31:0] word_buf;
    logic [5:0] presc;
    logic [31:0] op_count;
    logic [31:0] idle_count;
    logic wr_en;
    logic ctrl_wr;
    logic data_wr;
    logic tick;
    logic op_done;
    logic timeout_hit;
    logic ctrl_open;
    logic word_write_busy_flag;
    logic controller_busy_flag;
    logic [WORD_ADDR_W-1:0] word_addr;

    // APB access phase strobes
    assign wr_en = psel & penable & pwrite & pready;
    assign ctrl_wr = wr_en & (paddr == OFS_CONTROL);
    assign data_wr = wr_en & (paddr == OFS_WDATA) & (state == ST_COLLECT);
    assign ctrl_open = (state == ST_IDLE) | (state == ST_COLLECT);
    assign word_addr = {addr_high, addr_low}; // RULE2
    assign word_write_busy_flag = (state == ST_PROGRAM); // RULE5
    assign controller_busy_flag = (state != ST_IDLE);
    assign tick = (presc >= program_timing_setting - 6'h01) |
        (program_timing_setting == 6'h00); // RULE22
    assign op_done = (op_count == 32'h0) & tick;
    assign timeout_hit = (idle_count == 32'(TIMEOUT_CNT - 1));

    // Next sequencer state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (page_erase_bit | chip_erase_pend) begin
                    next_state = ST_ERASE; // RULE19
                end else if (write_start_bit) begin
                    next_state = ST_COLLECT; // RULE4
                end
            end
            ST_ERASE: begin
                if (op_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_COLLECT: begin
                if (!write_start_bit || timeout_hit) begin
                    next_state = ST_IDLE; // RULE20
                end else if (data_wr && byte_idx == 2'd3) begin
                    next_state = ST_PROGRAM; // RULE7
                end
            end
            ST_PROGRAM: begin
                if (op_done) begin
                    next_state = ST_COLLECT; // RULE8
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Control bits; erase requests and the write start bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_erase_bit <= 1'b0;
            chip_erase_pend <= 1'b0;
            write_start_bit <= 1'b0;
        end else begin
            if (ctrl_wr && ctrl_open) begin
                page_erase_bit <= pwdata[BIT_PAGE_ERASE] & (state == ST_IDLE);
                chip_erase_pend <= pwdata[BIT_CHIP_ERASE] & (state == ST_IDLE);
                write_start_bit <= pwdata[BIT_WRITE_START]; // RULE4 RULE16
            end else if (state == ST_ERASE && op_done) begin
                page_erase_bit <= 1'b0;
                chip_erase_pend <= 1'b0;
            end else if (state == ST_COLLECT && timeout_hit) begin
                write_start_bit <= 1'b0; // RULE20
            end
        end
    end

    // Address registers, advanced after each programmed word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low <= ADDR_LOW_RESET;
            addr_high <= ADDR_HIGH_RESET;
        end else if (state == ST_PROGRAM && op_done) begin
            {addr_high, addr_low} <= word_addr + 15'd1; // RULE8
        end else if (wr_en && !controller_busy_flag) begin
            if (paddr == OFS_ADDR_LOW) begin
                addr_low <= pwdata[7:0];
            end
            if (paddr == OFS_ADDR_HIGH) begin
                addr_high <= pwdata[6:0];
            end
        end
    end

    // Timing setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_timing_setting <= TIMING_RESET; // RULE22
        end else if (wr_en && paddr == OFS_TIMING &&
                     !controller_busy_flag) begin
            program_timing_setting <= pwdata[5:0];
        end
    end

    // Byte assembly, least significant byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_idx <= 2'd0;
            word_buf <= 32'h0;
        end else if (next_state == ST_COLLECT && state != ST_COLLECT &&
                     state != ST_PROGRAM) begin
            byte_idx <= 2'd0; // RULE23
        end else if (state == ST_COLLECT && next_state == ST_IDLE) begin
            byte_idx <= 2'd0; // RULE23
        end else if (data_wr) begin
            word_buf[byte_idx*8 +: 8] <= pwdata[7:0]; // RULE6
            byte_idx <= byte_idx + 2'd1;
        end
    end

    // Tick prescaler and operation duration counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= 6'h00;
            op_count <= 32'h0;
        end else if (next_state == ST_ERASE && state != ST_ERASE) begin
            presc <= 6'h00;
            op_count <= chip_erase_pend ? 32'(CHIP_TICKS - 1) :
                32'(PAGE_TICKS - 1); // RULE12 RULE13
        end else if (next_state == ST_PROGRAM && state != ST_PROGRAM) begin
            presc <= 6'h00;
            op_count <= 32'(PROG_TICKS - 1); // RULE11
        end else begin
            presc <= tick ? 6'h00 : presc + 6'h01;
            if (tick && op_count != 32'h0) begin
                op_count <= op_count - 32'h1;
            end
        end
    end

    // Word arrival timeout, restarted each time the port opens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_count <= 32'h0;
        end else if (state != ST_COLLECT) begin
            idle_count <= 32'h0;
        end else if (!timeout_hit) begin
            idle_count <= idle_count + 32'h1; // RULE20
        end
    end

    // Access violation flag; a new violation wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_violation <= 1'b0;
        end else if (cpu_flash_access && word_write_busy_flag) begin
            access_violation <= 1'b1; // RULE17
        end else if (wr_en && paddr == OFS_STATUS &&
                     pwdata[BIT_VIOLATION]) begin
            access_violation <= 1'b0;
        end
    end

    // Processor block, DMA request and array command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_flash_block <= 1'b0;
            dma_req <= 1'b0;
            flash_cmd <= '0;
        end else begin
            cpu_flash_block <= (next_state != ST_IDLE); // RULE14
            dma_req <= (next_state == ST_COLLECT) &&
                (state != ST_COLLECT); // RULE21
            flash_cmd.prog <= (next_state == ST_PROGRAM); // RULE5
            flash_cmd.page_erase <= (next_state == ST_ERASE) &
                ~chip_erase_pend; // RULE1 RULE10
            flash_cmd.chip_erase <= (next_state == ST_ERASE) &
                chip_erase_pend; // RULE10
            flash_cmd.page <= addr_high[PAGE_MSB:PAGE_LSB]; // RULE3
            flash_cmd.addr <= word_addr;
            // Data passes as written; the array only clears bits
            flash_cmd.data <= data_wr ?
                {pwdata[7:0], word_buf[23:0]} : word_buf; // RULE9
        end
    end

    // APB answer, prepared in the setup cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & (paddr > OFS_STATUS |
                paddr[1:0] != 2'b00);
            prdata <= 32'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    OFS_CONTROL: begin
                        prdata[BIT_PAGE_ERASE] <= page_erase_bit;
                        prdata[BIT_WRITE_START] <= write_start_bit;
                        prdata[BIT_CHIP_ERASE] <= chip_erase_pend;
                        prdata[BIT_WORD_BUSY] <= word_write_busy_flag;
                        prdata[BIT_CTRL_BUSY] <= controller_busy_flag;
                    end
                    OFS_ADDR_LOW: prdata[7:0] <= addr_low;
                    OFS_ADDR_HIGH: prdata[6:0] <= addr_high;
                    OFS_TIMING: prdata[5:0] <= program_timing_setting;
                    OFS_STATUS: prdata[BIT_VIOLATION] <= access_violation;
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fourth_byte;
        state == ST_COLLECT && data_wr && byte_idx == 2'd3 &&
            write_start_bit && !timeout_hit;
    endsequence

    sequence s_word_done;
        state == ST_PROGRAM && op_done;
    endsequence

    chk_four_bytes_prog: assert property ( // RULE7
        s_fourth_byte |=> state == ST_PROGRAM ##0 flash_cmd.prog)
        else $error("fourth byte did not start programming");
    chk_lsb_first: assert property ( // RULE6
        data_wr && byte_idx == 2'd0 && next_state == ST_COLLECT
        |=> word_buf[7:0] == $past(pwdata[7:0]))
        else $error("first byte not placed in low byte");
    chk_addr_advance: assert property ( // RULE8
        s_word_done |=> word_addr == $past(word_addr) + 15'd1)
        else $error("word address did not advance");
    chk_dma_after_word: assert property ( // RULE21
        s_word_done |=> dma_req ##1 !dma_req)
        else $error("no single dma request after word");
    chk_busy_while_prog: assert property ( // RULE5
        flash_cmd.prog |-> word_write_busy_flag && cpu_flash_block)
        else $error("word busy low while programming");
    chk_timeout_drop: assert property ( // RULE20
        state == ST_COLLECT && timeout_hit
        |=> !write_start_bit && byte_idx == 2'd0 && state == ST_IDLE)
        else $error("timeout did not drop write");
    chk_erase_first: assert property ( // RULE19
        state == ST_ERASE |-> !flash_cmd.prog && controller_busy_flag)
        else $error("programming during erase");
    chk_erase_page_sel: assert property ( // RULE3
        flash_cmd.page_erase |-> flash_cmd.page == addr_high[6:1])
        else $error("erase page not from high address");
    chk_violation_set: assert property ( // RULE17
        cpu_flash_access && word_write_busy_flag |=> access_violation)
        else $error("violation not flagged");
    chk_no_stall: assert property ( // RULE16
        psel && !penable |=> pready ##1 !pready)
        else $error("apb access stalled");
    chk_timing_reset: assert property ( // RULE22
        $rose(presetn) |-> program_timing_setting == TIMING_RESET)
        else $error("timing setting reset value wrong");
endmodule
`default_nettype wire

// >>> verification/flash_array_model.sv
// Behavioural flash array driven by the controller's command struct.
// Assumes each command is a level held for the whole operation.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
    import flash_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire flash_cmd_s cmd
);
    logic [31:0] mem [int];
    logic busy;
    logic busy_q = 1'b0;
    int run = 0;
    int last_len = 0;
    assign busy = cmd.prog | cmd.page_erase | cmd.chip_erase;
    // Words never programmed read as erased
    function automatic logic [31:0] peek(input int a);
        return mem.exists(a) ? mem[a] : 32'hffffffff;
    endfunction
    // Apply an operation as it starts, time how long it is held
    always @(posedge pclk) begin
        busy_q <= (busy === 1'b1);
        if (busy === 1'b1) begin
            run <= run + 1;
        end else if (busy_q) begin
            last_len <= run;
            run <= 0;
        end
        if (busy === 1'b1 && !busy_q) begin
            if (cmd.prog) begin
                mem[int'(cmd.addr)] = peek(int'(cmd.addr)) & cmd.data;
            end
            if (cmd.page_erase) begin
                for (int i = 0; i < PAGE_BYTES / 4; i++) begin
                    mem.delete(int'(cmd.page) * (PAGE_BYTES / 4) +
                        i);
                end
            end
            if (cmd.chip_erase) begin
                mem.delete();
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/test_embedded_flash_write_erase_ctrl.sv
// Self-checking bench for the flash controller over APB.
// Assumes shortened counts and the flash array model as far side.
`timescale 1ns/1ps
`default_nettype none
module test_embedded_flash_write_erase_ctrl;
    import flash_ctrl_pkg::*;
    localparam int PROG = 84;
    localparam int TMO = 84;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic cpu_flash_access;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_flash_block;
    logic dma_req;
    flash_cmd_s flash_cmd;
    logic op;
    logic [31:0] rdata;
    logic rerr;
    int errors = 0;
    int total_checks = 0;
    int dma_cnt = 0;
    int cyc = 0;
    assign op = flash_cmd.prog | flash_cmd.page_erase | flash_cmd.chip_erase;
    embedded_flash_write_erase_ctrl #(.PROG_CNT(PROG), .PAGE_ERASE_CNT(168),
        .CHIP_ERASE_CNT(252), .TIMEOUT_CNT(TMO)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_flash_access(cpu_flash_access),
        .cpu_flash_block(cpu_flash_block), .dma_req(dma_req),
        .flash_cmd(flash_cmd));
    flash_array_model flash (.pclk(pclk), .cmd(flash_cmd));
    // Clock, request counter and hang guard
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (dma_req === 1'b1) dma_cnt <= dma_cnt + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Waits sample at the edge; one more edge in wait_op lets the model settle
    task automatic wait_op(input logic lvl);
        for (int n = 0; n < 1000 && op !== lvl; n++) @(posedge pclk);
        if (op !== lvl) errors++;
        @(posedge pclk);
    endtask
    task automatic wait_dma();
        for (int n = 0; n < 100 && dma_req !== 1'b1; n++) @(posedge pclk);
        if (dma_req !== 1'b1) errors++;
    endtask
    // Four byte writes, least significant byte first
    task automatic send_word(input logic [31:0] d);
        for (int i = 0; i < 4; i++) wr(OFS_WDATA, {24'h0, d[i*8 +: 8]});
    endtask
    task automatic t_reset();
        rd(OFS_TIMING);
        chk(rdata, {26'h0, TIMING_RESET});
        rd(OFS_ADDR_LOW);
        chk(rdata, 32'h0);
        rd(OFS_ADDR_HIGH);
        chk(rdata, 32'h0);
        rd(8'h18);
        chk({31'h0, rerr}, 32'h1);
        rd(8'h02);
        chk({31'h0, rerr}, 32'h1);
    endtask
    task automatic t_words();
        wr(OFS_ADDR_HIGH, 32'h25);
        wr(OFS_ADDR_LOW, 32'hfe);
        wr(OFS_CONTROL, 32'h2);
        wait_dma();
        send_word(32'h89abcdef);
        wait_op(1'b1);
        chk({17'h0, flash_cmd.addr}, 32'h25fe);
        chk(flash_cmd.data, 32'h89abcdef);
        chk({31'h0, cpu_flash_block}, 32'h1);
        cpu_flash_access <= 1'b1;
        @(posedge pclk);
        cpu_flash_access <= 1'b0;
        rd(OFS_CONTROL);
        chk({31'h0, rdata[BIT_WORD_BUSY]}, 32'h1);
        wait_op(1'b0);
        chk(flash.last_len, PROG);
        rd(OFS_STATUS);
        chk({31'h0, rdata[BIT_VIOLATION]}, 32'h1);
        wr(OFS_STATUS, 32'h1);
        send_word(32'h0f0f00ff);
        wait_op(1'b1);
        chk({17'h0, flash_cmd.addr}, 32'h25ff);
        wait_op(1'b0);
        wr(OFS_CONTROL, 32'h0);
        rd(OFS_STATUS);
        chk(rdata, 32'h0);
        chk(dma_cnt, 3);
        chk(flash.peek(32'h25ff), 32'h0f0f00ff);
    endtask
    // Partial word left to expire, then a fresh start over old data
    task automatic t_timeout();
        wr(OFS_CONTROL, 32'h2);
        wait_dma();
        wr(OFS_WDATA, 32'h11);
        wr(OFS_WDATA, 32'h22);
        repeat (TMO + 20) @(posedge pclk);
        rd(OFS_CONTROL);
        chk(rdata & 32'h82, 32'h0);
        wr(OFS_ADDR_HIGH, 32'h25);
        wr(OFS_ADDR_LOW, 32'hfe);
        wr(OFS_CONTROL, 32'h2);
        wait_dma();
        send_word(32'hffff0000);
        wait_op(1'b1);
        chk(flash_cmd.data, 32'hffff0000);
        wait_op(1'b0);
        wr(OFS_CONTROL, 32'h0);
        chk(flash.peek(32'h25fe), 32'h89ab0000);
    endtask
    task automatic t_erase();
        wr(OFS_ADDR_LOW, 32'hfe);
        wr(OFS_CONTROL, 32'h3);
        wait_op(1'b1);
        chk({26'h0, flash_cmd.page}, 32'h12);
        chk({30'h0, flash_cmd.page_erase, flash_cmd.prog}, 32'h2);
        chk({31'h0, cpu_flash_block}, 32'h1);
        rd(OFS_CONTROL);
        chk({31'h0, rdata[BIT_CTRL_BUSY]}, 32'h1);
        wait_op(1'b0);
        chk(flash.last_len, 168);
        chk(flash.peek(32'h25ff), 32'hffffffff);
        send_word(32'h5a5a5a5a);
        wait_op(1'b1);
        chk({17'h0, flash_cmd.addr}, 32'h25fe);
        wait_op(1'b0);
        wr(OFS_CONTROL, 32'h0);
        chk(flash.peek(32'h25fe), 32'h5a5a5a5a);
    endtask
    // Half-rate timing setting scales program and chip erase
    task automatic t_timing();
        wr(OFS_TIMING, {26'h0, TIMING_16MHZ});
        rd(OFS_TIMING);
        chk(rdata, {26'h0, TIMING_16MHZ});
        wr(OFS_CONTROL, 32'h2);
        wait_dma();
        send_word(32'h0);
        wait_op(1'b1);
        wait_op(1'b0);
        chk(flash.last_len, PROG / 2);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, 32'h4);
        wait_op(1'b1);
        chk({31'h0, flash_cmd.chip_erase}, 32'h1);
        wait_op(1'b0);
        chk(flash.last_len, 126);
        chk(flash.peek(32'h25fe), 32'hffffffff);
    endtask
    // Reset, then the scenarios in order
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        cpu_flash_access <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_words();
        t_timeout();
        t_erase();
        t_timing();
        conclude();
    end
endmodule
`default_nettype wire
